// ### hdl/mcu_sfr.sv
// special-function register set of a 4-bit controller: flags, ports, timer,
// program-memory read-back, watchdog, halt and wake-up, reset merging.
// assumes the core presents one access per cycle and the rom array answers combinationally.
// Notes on behaviour
// R01 - flags in bits 1..0, upper bits read zero
// R02 - port a direction bits, spare bit three
// R03 - port a reads pins, writes drive 0..2
// R04 - port c: data, direction, wake, pull-up
// R05 - port b and d direction plus data
// R06 - timer control: run, overflow, prescale select
// R07 - timer held zero unless run enabled
// R08 - overflow on fe to ff, count wraps
// R09 - overflow flag sticky until software clears
// R10 - software reads count low then high
// R11 - ir pin level and carrier select, reset 1000
// R12 - ten-bit rom pointer, top bits zero
// R13 - rom word nibbles read at pointer
// R14 - writing 05h to 1dh clears watchdog
// R15 - optional watchdog resets system on timeout
// R16 - watchdog cleared on wake, reset, software
// R17 - six write-only extended registers in a sixteen-address space
// R18 - extended pull-up enables for a, b, d
// R19 - extended wake enables for a, b, d
// R20 - halt stops clock, pin edge wakes
// R21 - system reset ends halt normally
// R22 - reset merges power-on, low voltage, watchdog
// R23 - halt forces wake-enabled a, b pins input
// R24 - output pins read latch, pull-up off
// R25 - core clock is oscillator divided by four
// R26 - reserved and read-only writes ignored
// R27 - free-running prescaler, select applies next edge
module mcu_sfr #(
	parameter int DOG_CORE_TICKS = mcu_sfr_pkg::DOG_CORE_TICKS // watchdog period in core ticks
) (
	input  wire logic                  ref_clk_i,     // oscillator clock, 40 MHz
	input  wire logic                  nrst_i,        // power-on reset, active low
	input  wire logic                  low_voltage_reset_i, // low-voltage reset request
	input  wire logic                  dog_option_i,  // fixed watchdog enable option
	input  wire logic                  halt_i,        // halt instruction executed
	input  wire mcu_sfr_pkg::sfr_req_s req_i,         // register access from the core
	output logic [3:0]                 rdata_o,       // read data, next cycle
	output logic [9:0]                 rom_addr_o,    // program-memory read address
	input  wire logic [11:0]           rom_data_i,    // program word at rom_addr_o
	input  wire logic [3:0]            pa_i,          // port a pin levels
	output logic [2:0]                 pa_o,          // port a output latch
	output logic [2:0]                 pa_oe_o,       // port a drive enable
	output logic [3:0]                 pa_pu_o,       // port a pull-up on
	input  wire logic [3:0]            pb_i,          // port b pin levels
	output logic [3:0]                 pb_o,          // port b output latch
	output logic [3:0]                 pb_oe_o,       // port b drive enable
	output logic [3:0]                 pb_pu_o,       // port b pull-up on
	input  wire logic [3:0]            pd_i,          // port d pin levels
	output logic [3:0]                 pd_o,          // port d output latch
	output logic [3:0]                 pd_oe_o,       // port d drive enable
	output logic [3:0]                 pd_pu_o,       // port d pull-up on
	input  wire logic                  pc_i,          // port c pin level
	output logic                       pc_o,          // port c output latch
	output logic                       pc_oe_o,       // port c drive enable
	output logic                       pc_pu_o,       // port c pull-up on
	output logic                       ir_level_o,    // ir pin level
	output logic [2:0]                 carrier_sel_o, // ir carrier duty/frequency
	output logic                       osc_run_o,     // oscillator running
	output logic                       wake_o,        // resume at 004h, one pulse
	output logic                       sys_reset_o    // merged system reset, high
);

	localparam logic [mcu_sfr_pkg::DOG_W-1:0] DOG_LAST = mcu_sfr_pkg::DOG_W'(DOG_CORE_TICKS - 1);
	localparam logic [6:0] STABLE_LAST = mcu_sfr_pkg::STABLE_CORE_TICKS - 7'h01;

	mcu_sfr_pkg::sfr_state_s st_reg;
	mcu_sfr_pkg::sfr_state_s st_next;
	logic                         core_tick;
	logic [mcu_sfr_pkg::PRE_W-1:0] pre_inc;
	logic                         timer_tick;
	logic                         dog_ovf;
	logic                         wr_c;
	logic                         wr_x;
	logic [12:0]                  pins_now;
	logic [12:0]                  wake_en;
	logic                         wake_edge;
	logic                         in_halt;
	logic [3:0]                   rd_mux;

	// core clock tick; the oscillator, and with it every core tick, stops in halt
	assign core_tick = (st_reg.mode != mcu_sfr_pkg::MODE_HALTED)
		&& (st_reg.core_div == mcu_sfr_pkg::CORE_DIV_LAST); // R25

	// prescaler tap rises: the select only picks which bit is watched, so a change
	// takes effect at the next rising edge of the newly chosen bit
	assign pre_inc    = st_reg.pre + mcu_sfr_pkg::PRE_W'(1);
	assign timer_tick = core_tick
		&& !st_reg.pre[mcu_sfr_pkg::PRE_TAP_BASE + 3 - int'(st_reg.tctl[1:0])]
		&& pre_inc[mcu_sfr_pkg::PRE_TAP_BASE + 3 - int'(st_reg.tctl[1:0])]; // R27 R06

	// watchdog timeout, only with the option fitted
	assign dog_ovf = dog_option_i && core_tick && (st_reg.wdog == DOG_LAST); // R15

	// access decode
	assign wr_c = req_i.wr && !req_i.ext;
	assign wr_x = req_i.wr && req_i.ext; // R17

	// level-change wake: pa3 is input-only but can still wake
	assign pins_now  = {pc_i, pd_i, pb_i, pa_i};
	assign wake_en   = {st_reg.pc_ctl[2], st_reg.wk_d, st_reg.wk_b, st_reg.wk_a};
	assign wake_edge = |((pins_now ^ st_reg.pin_prev) & wake_en); // R20

	// read multiplexer; output pins return the latch, inputs the pin
	always_comb begin
		rd_mux = 4'h0; // reserved addresses read as zero R26
		case (req_i.addr)
			mcu_sfr_pkg::ADDR_FLAGS:     rd_mux = {2'b00, st_reg.carry_flag, st_reg.zero_flag}; // R01
			mcu_sfr_pkg::ADDR_A_DIR:     rd_mux = st_reg.dir_a; // R02
			mcu_sfr_pkg::ADDR_A_PINS:    rd_mux = {pa_i[3],
				(st_reg.oe_a & st_reg.lat_a) | (~st_reg.oe_a & pa_i[2:0])}; // R03 R24
			mcu_sfr_pkg::ADDR_C_CTRL:    rd_mux = {st_reg.pc_ctl[3:1],
				st_reg.oe_c ? st_reg.pc_ctl[0] : pc_i}; // R04 R24
			mcu_sfr_pkg::ADDR_B_DIR:     rd_mux = st_reg.dir_b; // R05
			mcu_sfr_pkg::ADDR_B_PINS:    rd_mux =
				(st_reg.oe_b & st_reg.lat_b) | (~st_reg.oe_b & pb_i); // R05 R24
			mcu_sfr_pkg::ADDR_SCRATCH_A: rd_mux = st_reg.scr_a;
			mcu_sfr_pkg::ADDR_D_DIR:     rd_mux = st_reg.dir_d; // R05
			mcu_sfr_pkg::ADDR_D_PINS:    rd_mux =
				(st_reg.oe_d & st_reg.lat_d) | (~st_reg.oe_d & pd_i); // R05 R24
			mcu_sfr_pkg::ADDR_TIMER_CTL: rd_mux = st_reg.tctl; // R06
			mcu_sfr_pkg::ADDR_SCRATCH_B: rd_mux = st_reg.scr_b;
			mcu_sfr_pkg::ADDR_COUNT_LO:  rd_mux = st_reg.count[3:0]; // R10
			mcu_sfr_pkg::ADDR_COUNT_HI:  rd_mux = st_reg.count[7:4]; // R10
			mcu_sfr_pkg::ADDR_IR_CTL:    rd_mux = st_reg.ir; // R11
			mcu_sfr_pkg::ADDR_PTR_LO:    rd_mux = st_reg.ptr[3:0]; // R12
			mcu_sfr_pkg::ADDR_PTR_MID:   rd_mux = st_reg.ptr[7:4]; // R12
			mcu_sfr_pkg::ADDR_PTR_HI:    rd_mux = {2'b00, st_reg.ptr[9:8]}; // R12
			mcu_sfr_pkg::ADDR_ROM_LO:    rd_mux = rom_data_i[3:0]; // R13
			mcu_sfr_pkg::ADDR_ROM_MID:   rd_mux = rom_data_i[7:4]; // R13 R14
			mcu_sfr_pkg::ADDR_ROM_HI:    rd_mux = rom_data_i[11:8]; // R13
			default:                     rd_mux = 4'h0;
		endcase
	end

	// next state of the whole register set
	always_comb begin
		st_next           = st_reg;
		st_next.wake      = 1'b0;
		st_next.sys_reset = 1'b0;
		st_next.pin_prev  = pins_now;

		// oscillator divider and free-running prescaler
		if (st_reg.mode != mcu_sfr_pkg::MODE_HALTED) begin
			st_next.core_div = st_reg.core_div + 2'h1; // R25
		end
		if (core_tick) begin
			st_next.pre = pre_inc; // R27
		end

		// software reads: the read-back is latched so the core sees a stable value
		if (req_i.rd && !req_i.ext) begin
			st_next.rdata = rd_mux;
		end

		// common-space writes; read-only fields and reserved addresses keep still R26
		if (wr_c) begin
			case (req_i.addr)
				mcu_sfr_pkg::ADDR_FLAGS: begin
					st_next.zero_flag  = req_i.data[0]; // R01
					st_next.carry_flag = req_i.data[1]; // R01
				end
				mcu_sfr_pkg::ADDR_A_DIR:     st_next.dir_a  = req_i.data; // R02
				mcu_sfr_pkg::ADDR_A_PINS:    st_next.lat_a  = req_i.data[2:0]; // R03
				mcu_sfr_pkg::ADDR_C_CTRL:    st_next.pc_ctl = req_i.data; // R04
				mcu_sfr_pkg::ADDR_B_DIR:     st_next.dir_b  = req_i.data; // R05
				mcu_sfr_pkg::ADDR_B_PINS:    st_next.lat_b  = req_i.data; // R05
				mcu_sfr_pkg::ADDR_SCRATCH_A: st_next.scr_a  = req_i.data;
				mcu_sfr_pkg::ADDR_D_DIR:     st_next.dir_d  = req_i.data; // R05
				mcu_sfr_pkg::ADDR_D_PINS:    st_next.lat_d  = req_i.data; // R05
				mcu_sfr_pkg::ADDR_TIMER_CTL: begin
					st_next.tctl[1:0] = req_i.data[1:0]; // R06
					st_next.tctl[mcu_sfr_pkg::TCTL_EN_BIT] =
						req_i.data[mcu_sfr_pkg::TCTL_EN_BIT]; // R06
					// writing 0 clears the flag, writing 1 leaves it alone
					if (!req_i.data[mcu_sfr_pkg::TCTL_FLAG_BIT]) begin
						st_next.tctl[mcu_sfr_pkg::TCTL_FLAG_BIT] = 1'b0; // R09
					end
				end
				mcu_sfr_pkg::ADDR_SCRATCH_B: st_next.scr_b   = req_i.data;
				mcu_sfr_pkg::ADDR_IR_CTL:    st_next.ir      = req_i.data; // R11
				mcu_sfr_pkg::ADDR_PTR_LO:    st_next.ptr[3:0] = req_i.data; // R12
				mcu_sfr_pkg::ADDR_PTR_MID:   st_next.ptr[7:4] = req_i.data; // R12
				mcu_sfr_pkg::ADDR_PTR_HI:    st_next.ptr[9:8] = req_i.data[1:0]; // R12
				default: ;
			endcase
		end

		// a pointer into the unreadable top area drops its bit 9
		if (st_next.ptr[9:5] == mcu_sfr_pkg::PTR_BAD_HEAD) begin
			st_next.ptr[9] = 1'b0; // R12
		end

		// extended-space stores, write-only
		if (wr_x) begin
			case (req_i.addr[3:0])
				mcu_sfr_pkg::EXT_A_PULLUP: st_next.pu_a = req_i.data; // R18
				mcu_sfr_pkg::EXT_B_PULLUP: st_next.pu_b = req_i.data; // R18
				mcu_sfr_pkg::EXT_D_PULLUP: st_next.pu_d = req_i.data; // R18
				mcu_sfr_pkg::EXT_A_WAKE:   st_next.wk_a = req_i.data; // R19
				mcu_sfr_pkg::EXT_B_WAKE:   st_next.wk_b = req_i.data; // R19
				mcu_sfr_pkg::EXT_D_WAKE:   st_next.wk_d = req_i.data; // R19
				default: ; // R26
			endcase
		end

		// timer: held at zero while stopped, wraps freely while running
		if (!st_reg.tctl[mcu_sfr_pkg::TCTL_EN_BIT]) begin
			st_next.count = 8'h00; // R07
		end else if (timer_tick) begin
			st_next.count = st_reg.count + 8'h01; // R07 R08
			if (st_reg.count == mcu_sfr_pkg::COUNT_PRE_TOP) begin
				// set wins over a clear in the same cycle
				st_next.tctl[mcu_sfr_pkg::TCTL_FLAG_BIT] = 1'b1; // R08 R09
			end
		end

		// watchdog counts core ticks; cleared by the key write or a wake-up
		if (!dog_option_i) begin
			st_next.wdog = '0; // R15
		end else if (core_tick) begin
			st_next.wdog = st_reg.wdog + mcu_sfr_pkg::DOG_W'(1); // R15
		end
		if (wr_c && req_i.addr == mcu_sfr_pkg::ADDR_ROM_MID
			&& req_i.data == mcu_sfr_pkg::DOG_CLEAR_KEY) begin
			st_next.wdog = '0; // R14 R16
		end

		// halt and wake sequence
		case (st_reg.mode)
			mcu_sfr_pkg::MODE_RUN: begin
				if (halt_i) begin
					st_next.mode     = mcu_sfr_pkg::MODE_HALTED; // R20
					st_next.core_div = 2'h0;
				end
			end
			mcu_sfr_pkg::MODE_HALTED: begin
				if (wake_edge) begin
					st_next.mode   = mcu_sfr_pkg::MODE_STABLE; // R20
					st_next.stable = 7'h00;
					st_next.wdog   = '0; // R16
				end
			end
			mcu_sfr_pkg::MODE_STABLE: begin
				// the core is released only after the clock has settled
				if (core_tick) begin
					st_next.stable = st_reg.stable + 7'h01;
					if (st_reg.stable == STABLE_LAST) begin
						st_next.mode = mcu_sfr_pkg::MODE_RUN; // R20
						st_next.wake = 1'b1; // R20
					end
				end
			end
			default: st_next.mode = mcu_sfr_pkg::MODE_RUN;
		endcase
		st_next.osc_run = (st_next.mode != mcu_sfr_pkg::MODE_HALTED); // R20

		// pin drivers follow the next state so outputs stay registered
		in_halt        = (st_next.mode != mcu_sfr_pkg::MODE_RUN);
		st_next.oe_a   = st_next.dir_a[2:0] & ~({3{in_halt}} & st_next.wk_a[2:0]); // R02 R23
		st_next.oe_b   = st_next.dir_b & ~({4{in_halt}} & st_next.wk_b); // R05 R23
		st_next.oe_d   = st_next.dir_d; // R05
		st_next.oe_c   = st_next.pc_ctl[1]; // R04
		st_next.pull_a = st_next.pu_a & ~{1'b0, st_next.oe_a}; // R18 R24
		st_next.pull_b = st_next.pu_b & ~st_next.oe_b; // R18 R24
		st_next.pull_d = st_next.pu_d & ~st_next.oe_d; // R18 R24
		st_next.pull_c = st_next.pc_ctl[3] & ~st_next.oe_c; // R04 R24

		// low-voltage or watchdog reset restarts everything; a low-voltage reset also ends halt, where the watchdog does not count
		if (low_voltage_reset_i || dog_ovf) begin
			st_next = mcu_sfr_pkg::STATE_RESET; // R21 R22
		end
	end

	// single state register; power-on reset is the asynchronous source
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= mcu_sfr_pkg::STATE_RESET; // R16 R22
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign rdata_o       = st_reg.rdata;
	assign rom_addr_o    = st_reg.ptr;
	assign pa_o          = st_reg.lat_a;
	assign pa_oe_o       = st_reg.oe_a;
	assign pa_pu_o       = st_reg.pull_a;
	assign pb_o          = st_reg.lat_b;
	assign pb_oe_o       = st_reg.oe_b;
	assign pb_pu_o       = st_reg.pull_b;
	assign pd_o          = st_reg.lat_d;
	assign pd_oe_o       = st_reg.oe_d;
	assign pd_pu_o       = st_reg.pull_d;
	assign pc_o          = st_reg.pc_ctl[0];
	assign pc_oe_o       = st_reg.oe_c;
	assign pc_pu_o       = st_reg.pull_c;
	assign ir_level_o    = st_reg.ir[3]; // R11
	assign carrier_sel_o = st_reg.ir[2:0]; // R11
	assign osc_run_o     = st_reg.osc_run;
	assign wake_o        = st_reg.wake;
	assign sys_reset_o   = st_reg.sys_reset;

	// checks on the behaviour above
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	a_flag_upper_zero: assert property ( // R01
		req_i.rd && !req_i.ext && req_i.addr == mcu_sfr_pkg::ADDR_FLAGS |=> rdata_o[3:2] == 2'b00)
		else $error("flag nibble upper bits not zero");

	a_timer_held_zero: assert property ( // R07
		!$past(st_reg.tctl[mcu_sfr_pkg::TCTL_EN_BIT]) |-> st_reg.count == 8'h00)
		else $error("timer count moved while stopped");

	a_overflow_set: assert property ( // R08
		timer_tick && st_reg.tctl[mcu_sfr_pkg::TCTL_EN_BIT]
		&& !low_voltage_reset_i && !dog_ovf
		&& st_reg.count == mcu_sfr_pkg::COUNT_PRE_TOP
		|=> st_reg.count == mcu_sfr_pkg::COUNT_TOP && st_reg.tctl[mcu_sfr_pkg::TCTL_FLAG_BIT])
		else $error("overflow flag not set on fe to ff");

	a_count_wraps: assert property ( // R08
		timer_tick && st_reg.tctl[mcu_sfr_pkg::TCTL_EN_BIT]
		&& !low_voltage_reset_i && !dog_ovf
		&& st_reg.count == mcu_sfr_pkg::COUNT_TOP |=> st_reg.count == 8'h00)
		else $error("timer count did not wrap");

	a_flag_sticky: assert property ( // R09
		st_reg.tctl[mcu_sfr_pkg::TCTL_FLAG_BIT] && !low_voltage_reset_i && !dog_ovf
		&& !(wr_c && req_i.addr == mcu_sfr_pkg::ADDR_TIMER_CTL && !req_i.data[2])
		|=> st_reg.tctl[mcu_sfr_pkg::TCTL_FLAG_BIT])
		else $error("overflow flag dropped without a clear");

	a_ptr_top_zero: assert property ( // R12
		req_i.rd && !req_i.ext && req_i.addr == mcu_sfr_pkg::ADDR_PTR_HI |=> rdata_o[3:2] == 2'b00)
		else $error("pointer top bits not zero");

	a_dog_clear: assert property ( // R14
		wr_c && req_i.addr == mcu_sfr_pkg::ADDR_ROM_MID && req_i.data == mcu_sfr_pkg::DOG_CLEAR_KEY
		|=> st_reg.wdog == '0)
		else $error("watchdog not cleared by key write");

	a_wake_delay: assert property ( // R20
		st_reg.mode == mcu_sfr_pkg::MODE_HALTED && wake_edge && !low_voltage_reset_i
		|=> !wake_o [*8] ##[248:260] wake_o)
		else $error("wake pulse not after stable delay");

	a_halt_input: assert property ( // R23
		st_reg.mode != mcu_sfr_pkg::MODE_RUN
		|-> (pa_oe_o & st_reg.wk_a[2:0]) == 3'h0 && (pb_oe_o & st_reg.wk_b) == 4'h0)
		else $error("wake pin still driven in halt");

	a_output_no_pullup: assert property ( // R24
		(pb_oe_o & pb_pu_o) == 4'h0 && (pa_oe_o & pa_pu_o[2:0]) == 3'h0)
		else $error("pull-up on an output pin");

	a_dog_resets: assert property ( // R22
		dog_ovf |=> sys_reset_o && st_reg.mode == mcu_sfr_pkg::MODE_RUN && st_reg.ir == 4'h8)
		else $error("watchdog overflow did not reset");

	a_halt_stops_osc: assert property ( // R20
		halt_i && st_reg.mode == mcu_sfr_pkg::MODE_RUN
		&& !low_voltage_reset_i && !dog_ovf |=> !osc_run_o)
		else $error("oscillator still running after halt");

	a_lvr_ends_halt: assert property ( // R21
		low_voltage_reset_i
		|=> sys_reset_o && osc_run_o && !wake_o && st_reg.mode == mcu_sfr_pkg::MODE_RUN)
		else $error("low-voltage reset did not restart normally");

	a_dog_off_idle: assert property ( // R15
		!dog_option_i && !low_voltage_reset_i |=> st_reg.wdog == '0 && !sys_reset_o)
		else $error("watchdog active with option off");

endmodule : mcu_sfr

// ### hdl/mcu_sfr_pkg.sv
// package of the special-function register set: addresses, reset values, types.
// assumes a single 40 MHz reference clock standing in for the fast rc oscillator.
package mcu_sfr_pkg;

	// common space addresses
	localparam logic [4:0] ADDR_FLAGS     = 5'h00;
	localparam logic [4:0] ADDR_A_DIR     = 5'h02;
	localparam logic [4:0] ADDR_A_PINS    = 5'h03;
	localparam logic [4:0] ADDR_C_CTRL    = 5'h04;
	localparam logic [4:0] ADDR_B_DIR     = 5'h05;
	localparam logic [4:0] ADDR_B_PINS    = 5'h06;
	localparam logic [4:0] ADDR_SCRATCH_A = 5'h07;
	localparam logic [4:0] ADDR_D_DIR     = 5'h0c;
	localparam logic [4:0] ADDR_D_PINS    = 5'h0d;
	localparam logic [4:0] ADDR_TIMER_CTL = 5'h0e;
	localparam logic [4:0] ADDR_SCRATCH_B = 5'h0f;
	localparam logic [4:0] ADDR_COUNT_LO  = 5'h11;
	localparam logic [4:0] ADDR_COUNT_HI  = 5'h12;
	localparam logic [4:0] ADDR_IR_CTL    = 5'h13;
	localparam logic [4:0] ADDR_PTR_LO    = 5'h18;
	localparam logic [4:0] ADDR_PTR_MID   = 5'h19;
	localparam logic [4:0] ADDR_PTR_HI    = 5'h1a;
	localparam logic [4:0] ADDR_ROM_LO    = 5'h1c;
	localparam logic [4:0] ADDR_ROM_MID   = 5'h1d;
	localparam logic [4:0] ADDR_ROM_HI    = 5'h1e;

	// extended space addresses
	localparam logic [3:0] EXT_A_PULLUP = 4'h0;
	localparam logic [3:0] EXT_B_PULLUP = 4'h2;
	localparam logic [3:0] EXT_D_PULLUP = 4'h4;
	localparam logic [3:0] EXT_A_WAKE   = 4'h6;
	localparam logic [3:0] EXT_B_WAKE   = 4'h7;
	localparam logic [3:0] EXT_D_WAKE   = 4'h8;

	// field positions and special values
	localparam int         TCTL_EN_BIT   = 3;
	localparam int         TCTL_FLAG_BIT = 2;
	localparam logic [3:0] IR_RESET      = 4'h8;
	localparam logic [3:0] DOG_CLEAR_KEY = 4'h5;
	localparam logic [7:0] COUNT_PRE_TOP = 8'hfe;
	localparam logic [7:0] COUNT_TOP     = 8'hff;
	localparam logic [4:0] PTR_BAD_HEAD  = 5'h13; // pointer bits 9..5 of 260h..27fh

	// timing: core clock is the oscillator divided by four
	localparam int         REF_CLK_HZ        = 40000000;
	localparam int         CORE_DIV          = 4;
	localparam logic [1:0] CORE_DIV_LAST     = 2'(CORE_DIV - 1);
	localparam int         PRE_W             = 13;  // divides up to 8192
	localparam int         PRE_TAP_BASE      = 9;   // tap for divide by 1024
	localparam real        DOG_PERIOD_S      = 0.262;
	localparam int         DOG_CORE_TICKS    = $rtoi(DOG_PERIOD_S * REF_CLK_HZ / CORE_DIV);
	localparam int         DOG_W             = 22;
	localparam logic [6:0] STABLE_CORE_TICKS = 7'h40;

	// operating modes, one-hot
	typedef enum logic [2:0] {
		MODE_RUN    = 3'h1,
		MODE_HALTED = 3'h2,
		MODE_STABLE = 3'h4
	} mode_e;

	// one register access from the core
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       ext;   // extended-space store
		logic [4:0] addr;
		logic [3:0] data;
	} sfr_req_s;

	// whole state of the register set
	typedef struct packed {
		logic              zero_flag;
		logic              carry_flag;
		logic [3:0]        dir_a;
		logic [2:0]        lat_a;
		logic [3:0]        pc_ctl;
		logic [3:0]        dir_b;
		logic [3:0]        lat_b;
		logic [3:0]        scr_a;
		logic [3:0]        dir_d;
		logic [3:0]        lat_d;
		logic [3:0]        tctl;
		logic [3:0]        scr_b;
		logic [7:0]        count;
		logic [3:0]        ir;
		logic [9:0]        ptr;
		logic [3:0]        pu_a;
		logic [3:0]        pu_b;
		logic [3:0]        pu_d;
		logic [3:0]        wk_a;
		logic [3:0]        wk_b;
		logic [3:0]        wk_d;
		logic [PRE_W-1:0]  pre;
		logic [1:0]        core_div;
		logic [DOG_W-1:0]  wdog;
		logic [6:0]        stable;
		mode_e             mode;
		logic [12:0]       pin_prev;
		logic [3:0]        rdata;
		logic [2:0]        oe_a;
		logic [3:0]        oe_b;
		logic [3:0]        oe_d;
		logic              oe_c;
		logic [3:0]        pull_a;
		logic [3:0]        pull_b;
		logic [3:0]        pull_d;
		logic              pull_c;
		logic              wake;
		logic              sys_reset;
		logic              osc_run;
	} sfr_state_s;

	localparam sfr_state_s STATE_RESET = '{
		ir: IR_RESET, mode: MODE_RUN, sys_reset: 1'b1, osc_run: 1'b1, default: '0};

endpackage : mcu_sfr_pkg

// ### test/rom_model.sv
// program-memory array standing behind the register set's read-back port.
// assumes the design registers the pointer; the word answers combinationally.
module rom_model (
	input  wire logic [9:0]  addr_i, // word address from the pointer
	output logic      [11:0] data_o  // program word at that address
);
	timeunit 1ns;
	timeprecision 100ps;
	// word mixes its own address so every nibble position differs
	assign data_o = {addr_i[1:0], addr_i} ^ 12'h6b5;
endmodule : rom_model

// ### test/test_mcu_sfr.sv
// self-checking bench of the register set: core accesses, ports, timer, dog, halt.
// assumes a rom model on the read-back port; far-side pins driven by the bench.
module test_mcu_sfr;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i, nrst_i, low_voltage_reset_i, dog_option_i, halt_i;
	logic pc_i, pc_o, pc_oe_o, pc_pu_o;
	logic ir_level_o, osc_run_o, wake_o, sys_reset_o;
	logic [2:0] pa_o, pa_oe_o, carrier_sel_o;
	logic [3:0] rdata_o, pa_i, pa_pu_o, pb_i, pb_o, pb_oe_o, pb_pu_o, pd_i, pd_o, pd_oe_o, pd_pu_o;
	logic [9:0] rom_addr_o;
	logic [11:0] rom_data_i;
	logic [3:0] a;
	mcu_sfr_pkg::sfr_req_s req_i;
	int bad_count, check_count, n;
	mcu_sfr #(.DOG_CORE_TICKS(50)) dut (.ref_clk_i, .nrst_i, .low_voltage_reset_i,
		.dog_option_i, .halt_i,
		.req_i, .rdata_o, .rom_addr_o, .rom_data_i, .pa_i, .pa_o, .pa_oe_o, .pa_pu_o, .pb_i,
		.pb_o, .pb_oe_o, .pb_pu_o, .pd_i, .pd_o, .pd_oe_o, .pd_pu_o, .pc_i, .pc_o, .pc_oe_o,
		.pc_pu_o, .ir_level_o, .carrier_sel_o, .osc_run_o, .wake_o, .sys_reset_o);
	rom_model rom (.addr_i(rom_addr_o), .data_o(rom_data_i));
	// reference clock, 40 MHz
	initial begin
		ref_clk_i = 0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int c);
		repeat (c) @(negedge ref_clk_i);
	endtask : cyc
	// one core access, held for a single taking edge
	task automatic acc(input logic rd, input logic ext, input logic [4:0] ad, input logic [3:0] d);
		@(negedge ref_clk_i);
		req_i = '{rd: rd, wr: !rd, ext: ext, addr: ad, data: d};
		@(negedge ref_clk_i);
		req_i = '0;
	endtask : acc
	task automatic rd_chk(input logic [4:0] ad, input logic [3:0] e);
		acc(1, 0, ad, 0);
		check(rdata_o, e);
	endtask : rd_chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	// hang guard, reckoned well beyond the timer waits
	initial begin
		#(60000 * 25);
		bad_count++;
		end_sim;
	end
	initial begin
		{nrst_i, low_voltage_reset_i, dog_option_i, halt_i, pc_i, pb_i, pd_i} = '0;
		pa_i = 4'ha;
		req_i = '0;
		cyc(3);
		nrst_i = 1;
		rd_chk(5'h02, 0);
		rd_chk(5'h0e, 0);
		rd_chk(5'h13, 8);
		rd_chk(5'h12, 0);
		acc(0, 0, 5'h00, 4'hf);
		rd_chk(5'h00, 3);
		acc(0, 0, 5'h01, 4'hf);
		rd_chk(5'h01, 0);
		acc(0, 0, 5'h02, 4'h7);
		acc(0, 0, 5'h03, 4'h5);
		rd_chk(5'h03, 4'hd);
		check({pa_oe_o, pa_o}, 6'h3d);
		acc(0, 1, 5'h00, 4'hf);
		acc(0, 1, 5'h02, 4'hf);
		check({pa_pu_o, pb_pu_o}, 8'h8f);
		acc(0, 0, 5'h05, 4'h5);
		acc(0, 0, 5'h06, 4'h3);
		rd_chk(5'h06, 1);
		check({pb_oe_o, pb_o, pb_pu_o}, 12'h53a);
		acc(0, 0, 5'h04, 4'hb);
		rd_chk(5'h04, 4'hb);
		check({pc_o, pc_oe_o, pc_pu_o}, 3'h6);
		acc(0, 1, 5'h04, 4'h3);
		check(pd_pu_o, 3);
		acc(0, 0, 5'h0c, 4'hf);
		acc(0, 0, 5'h0d, 4'h6);
		rd_chk(5'h0d, 6);
		check({pd_oe_o, pd_o, pd_pu_o}, 12'hf60);
		$display("ports done");
		acc(0, 0, 5'h18, 4'h6);
		acc(0, 0, 5'h19, 4'h5);
		acc(0, 0, 5'h1a, 4'hd);
		rd_chk(5'h1a, 1);
		check(rom_addr_o, 10'h156);
		rd_chk(5'h1c, 4'h3);
		rd_chk(5'h1d, 4'he);
		rd_chk(5'h1e, 4'hf);
		$display("rom done");
		// one prescaled period must step the count by exactly one
		for (int s = 2; s < 4; s++) begin
			acc(0, 0, 5'h0e, 4'(8 + s));
			// a period is the divisor times four reference clocks
			cyc(8192 >> (s - 2));
			acc(1, 0, 5'h11, 0);
			a = rdata_o;
			cyc((8192 >> (s - 2)) - 2);
			rd_chk(5'h11, a + 4'h1);
		end
		rd_chk(5'h12, 0);
		acc(0, 0, 5'h0e, 4'h3);
		rd_chk(5'h11, 0);
		$display("timer done");
		acc(0, 0, 5'h13, 4'h3);
		check({ir_level_o, carrier_sel_o}, 4'h3);
		dog_option_i = 1;
		acc(0, 0, 5'h1d, 4'h5);
		cyc(150);
		acc(0, 0, 5'h1d, 4'h5);
		cyc(150);
		rd_chk(5'h13, 3);
		cyc(120);
		rd_chk(5'h13, 8);
		dog_option_i = 0;
		$display("watchdog done");
		acc(0, 1, 5'h06, 4'h1);
		acc(0, 0, 5'h02, 4'h1);
		halt_i = 1;
		cyc(1);
		halt_i = 0;
		cyc(2);
		check({osc_run_o, pa_oe_o}, 0);
		pa_i = 4'hb;
		cyc(2);
		check(osc_run_o, 1);
		n = 0;
		while (wake_o !== 1'b1 && n < 400) begin
			cyc(1);
			n++;
		end
		check(wake_o, 1);
		check(pa_oe_o, 1);
		$display("halt done");
		halt_i = 1;
		cyc(1);
		halt_i = 0;
		low_voltage_reset_i = 1;
		check(osc_run_o, 0);
		cyc(1);
		check({osc_run_o, sys_reset_o, wake_o}, 3'h6);
		low_voltage_reset_i = 0;
		rd_chk(5'h02, 0);
		$display("reset done");
		end_sim;
	end
endmodule : test_mcu_sfr
